// [hdl/mfp_regs.svh]
// Register indices, field positions and reset values of the multifunction port
`ifndef MFP_REGS_SVH
`define MFP_REGS_SVH

// Register indices; the bus byte address is four times the index
`define MFP_IDX_LATCH     12'h000
`define MFP_IDX_DIR       12'h010
`define MFP_IDX_SEG       12'hFAC
`define MFP_IDX_ROUTE     12'hFBB

// Reset values
`define MFP_RST_LATCH     8'h00
`define MFP_RST_DIR       8'h00
`define MFP_RST_SEG       8'h00
`define MFP_RST_ROUTE     2'h0

// Routing register fields
`define MFP_ROUTE_UART    0
`define MFP_ROUTE_SIO     1

// Port bit assignment of the shared functions
`define MFP_BIT_RX        0
`define MFP_BIT_TX        1
`define MFP_BIT_INT_LO    2
`define MFP_BIT_INT_HI    4
`define MFP_BIT_SI        5
`define MFP_BIT_SO        6
`define MFP_BIT_SCK       7

`endif

// [hdl/mfp_pkg.sv]
// Types shared by the multifunction port modules
package mfp_pkg;

    // Outputs of the UART and serial engines toward the pins
    typedef struct packed {
        logic uart_tx;      // UART transmit
        logic sio_out;      // Serial data out
        logic sio_clk_out;  // Serial clock out
        logic sio_clk_oe;   // Serial clock driven (master)
    } mfp_func_out_type;

    // Pin levels handed to the UART, serial engine and interrupt logic
    typedef struct packed {
        logic       uart_rx;     // UART receive
        logic       sio_in;      // Serial data in
        logic       sio_clk_in;  // Serial clock in
        logic [2:0] ext_int;     // External interrupts three to one
    } mfp_func_in_type;

    // Levels of the alternate pins on the other ports
    typedef struct packed {
        logic uart_rx;   // Port-three bit 7
        logic sio_in;    // Port-four bit 0
        logic sio_clk;   // Port-four bit 2
    } mfp_alt_in_type;

    // Whole state of the port block
    typedef struct packed {
        logic [7:0]       latch;        // Output latch
        logic [7:0]       dir;          // Direction, 1 = output
        logic [7:0]       seg;          // Segment select
        logic [1:0]       route;        // Pin routing select
        logic [7:0]       pin_s1;       // Pin synchroniser stage 1
        logic [7:0]       pin_s2;       // Pin synchroniser stage 2
        mfp_alt_in_type   alt_s1;       // Alternate pin stage 1
        mfp_alt_in_type   alt_s2;       // Alternate pin stage 2
        logic [7:0]       pin_out;      // Registered pin drive
        logic [7:0]       pin_oe;       // Registered pin enable
        mfp_func_in_type  func_in;      // Registered peripheral inputs
        mfp_func_out_type alt_out;      // Registered alternate drive
        logic [31:0]      readdata;     // Bus read data
        logic             waitrequest;  // Bus wait
    } mfp_state_type;

endpackage

// [hdl/mfp_pin_mux.sv]
// Per-pin function multiplexer of the multifunction port
`timescale 1ns/1ps
`default_nettype none
`include "mfp_regs.svh"

module mfp_pin_mux (
    input  wire logic [7:0]                latch,
    input  wire logic [7:0]                dir,
    input  wire logic [7:0]                seg,
    input  wire logic [1:0]                route,
    input  wire logic [7:0]                lcd_seg,
    input  wire logic [7:0]                pin_level,
    input  wire mfp_pkg::mfp_func_out_type func_out,
    input  wire mfp_pkg::mfp_alt_in_type   alt_level,
    output logic [7:0]                     pin_out,
    output logic [7:0]                     pin_oe,
    output logic [7:0]                     port_read,
    output var mfp_pkg::mfp_func_in_type   func_in,
    output var mfp_pkg::mfp_func_out_type  alt_out
);
    import mfp_pkg::*;

    logic [7:0] func_mask;  // Peripheral gating of latch bits

    // Functions routed to this port gate the latch, which must hold 1
    always_comb begin
        func_mask = 8'hFF;
        if (!route[`MFP_ROUTE_UART]) begin
            func_mask[`MFP_BIT_TX] = func_out.uart_tx;
        end
        if (!route[`MFP_ROUTE_SIO]) begin
            func_mask[`MFP_BIT_SO]  = func_out.sio_out;
            func_mask[`MFP_BIT_SCK] = func_out.sio_clk_out;
        end
    end

    assign pin_out = (seg & lcd_seg) | (~seg & latch & func_mask);
    assign pin_oe  = seg | dir;

    assign port_read = (dir & latch) | (~dir & ~seg & pin_level);

    always_comb begin
        func_in.ext_int    = pin_level[`MFP_BIT_INT_HI:`MFP_BIT_INT_LO];
        func_in.uart_rx    = route[`MFP_ROUTE_UART] ? alt_level.uart_rx : pin_level[`MFP_BIT_RX];
        func_in.sio_in     = route[`MFP_ROUTE_SIO] ? alt_level.sio_in : pin_level[`MFP_BIT_SI];
        func_in.sio_clk_in = route[`MFP_ROUTE_SIO] ? alt_level.sio_clk : pin_level[`MFP_BIT_SCK];
    end

    // alternate pins idle high when not routed there
    always_comb begin
        alt_out.uart_tx     = route[`MFP_ROUTE_UART] ? func_out.uart_tx : 1'b1;
        alt_out.sio_out     = route[`MFP_ROUTE_SIO] ? func_out.sio_out : 1'b1;
        alt_out.sio_clk_out = route[`MFP_ROUTE_SIO] ? func_out.sio_clk_out : 1'b1;
        alt_out.sio_clk_oe  = route[`MFP_ROUTE_SIO] & func_out.sio_clk_oe;
    end

endmodule // mfp_pin_mux

`default_nettype wire

// [hdl/mfp_port.sv]
// Multifunction port zero with pin routing, Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "mfp_regs.svh"

// Summary of operation
// - Each pin's direction set by its own bit
// - Segment bit 1 forces LCD segment drive
// - Reset clears latch, direction, segment registers
// - Input pins read back live pin level
// - Segment input pins read back zero
// - Output pins read back latch contents
// - Bit read-modify-write copies pin levels into latch
// - Routing bit 1 moves serial pins
// - Routing bit 0 moves UART pins
// - Pins sampled on read, outputs change on write
// - Outputs latched, inputs pass two synchroniser stages
module mfp_port (
    input  wire logic                      sys_clk,
    input  wire logic                      nrst,
    input  wire logic [13:0]               avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [3:0]                avs_byteenable,
    input  wire logic [31:0]               avs_writedata,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic [7:0]                pin_in,
    output logic [7:0]                     pin_out,
    output logic [7:0]                     pin_oe,
    input  wire logic [7:0]                lcd_seg,
    input  wire mfp_pkg::mfp_func_out_type func_out,
    output var mfp_pkg::mfp_func_in_type   func_in,
    input  wire mfp_pkg::mfp_alt_in_type   alt_in,
    output var mfp_pkg::mfp_func_out_type  alt_out
);
    import mfp_pkg::*;

    // Reset image of the whole state
    localparam mfp_state_type ST_RESET = '{
        latch       : `MFP_RST_LATCH,
        dir         : `MFP_RST_DIR,
        seg         : `MFP_RST_SEG,
        route       : `MFP_RST_ROUTE,
        pin_s1      : 8'h00,
        pin_s2      : 8'h00,
        alt_s1      : 3'h0,
        alt_s2      : 3'h0,
        pin_out     : 8'h00,
        pin_oe      : 8'h00,
        func_in     : 6'h00,
        alt_out     : 4'hE,
        readdata    : 32'h0000_0000,
        waitrequest : 1'b1
    };

    mfp_state_type    st_q;       // Registered state
    mfp_state_type    st_d;       // Next state
    logic [7:0]       mux_out;    // Pin drive from the multiplexer
    logic [7:0]       mux_oe;     // Pin enable from the multiplexer
    logic [7:0]       port_read;  // Data register read value
    mfp_func_in_type  mux_fin;    // Peripheral inputs from the multiplexer
    mfp_func_out_type mux_alt;    // Alternate pin drive from the multiplexer
    logic             req_new;    // Request seen, answer not yet given
    logic             req_done;   // Request completes at this edge
    logic             wr_lane0;   // Write to the low byte completes

    // Byte address of a register index matches the bus address
    function automatic logic hits(input logic [13:0] addr, input logic [11:0] idx);
        return addr == {idx, 2'b00};
    endfunction

    // Read value of an address, narrow data in the low byte
    function automatic logic [31:0] read_word(input logic [13:0] addr, input mfp_state_type s,
                                              input logic [7:0] pread);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (hits(addr, `MFP_IDX_LATCH)) begin
            w[7:0] = pread;
        end else if (hits(addr, `MFP_IDX_DIR)) begin
            w[7:0] = s.dir;
        end else if (hits(addr, `MFP_IDX_SEG)) begin
            w[7:0] = s.seg;
        end else if (hits(addr, `MFP_IDX_ROUTE)) begin
            w[1:0] = s.route;
        end
        return w;
    endfunction

    // Pin function multiplexer works on the synchronised levels
    mfp_pin_mux u_mux (
        .latch     (st_q.latch),
        .dir       (st_q.dir),
        .seg       (st_q.seg),
        .route     (st_q.route),
        .lcd_seg   (lcd_seg),
        .pin_level (st_q.pin_s2),
        .func_out  (func_out),
        .alt_level (st_q.alt_s2),
        .pin_out   (mux_out),
        .pin_oe    (mux_oe),
        .port_read (port_read),
        .func_in   (mux_fin),
        .alt_out   (mux_alt)
    );

    // Bus handshake terms
    assign req_new  = (avs_read | avs_write) & st_q.waitrequest;
    assign req_done = (avs_read | avs_write) & ~st_q.waitrequest;
    assign wr_lane0 = avs_write & ~st_q.waitrequest & avs_byteenable[0];

    // Next state of the whole block
    always_comb begin
        st_d = st_q;
        // pins sampled without a latch, two stages
        st_d.pin_s1 = pin_in;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.alt_s1 = alt_in;
        st_d.alt_s2 = st_q.alt_s1;
        // Outputs registered from the multiplexer
        st_d.pin_out = mux_out;
        st_d.pin_oe  = mux_oe;
        st_d.func_in = mux_fin;
        st_d.alt_out = mux_alt;
        // One-cycle wait, then a one-cycle answer
        st_d.waitrequest = 1'b1;
        if (req_new) begin
            // pin sampled in the read cycle
            st_d.waitrequest = 1'b0;
            st_d.readdata    = avs_read ? read_word(avs_address, st_q, port_read) : 32'h0000_0000;
        end
        // bit RMW writes back pin levels read
        if (wr_lane0) begin
            if (hits(avs_address, `MFP_IDX_LATCH)) begin
                st_d.latch = avs_writedata[7:0];
            end else if (hits(avs_address, `MFP_IDX_DIR)) begin
                st_d.dir = avs_writedata[7:0];
            end else if (hits(avs_address, `MFP_IDX_SEG)) begin
                st_d.seg = avs_writedata[7:0];
            end else if (hits(avs_address, `MFP_IDX_ROUTE)) begin
                st_d.route = avs_writedata[1:0];
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata    = st_q.readdata;
    assign avs_waitrequest = st_q.waitrequest;
    assign pin_out         = st_q.pin_out;
    assign pin_oe          = st_q.pin_oe;
    assign func_in         = st_q.func_in;
    assign alt_out         = st_q.alt_out;

    // Checks on the port behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // Direction write reaches the pin enables two edges later
    dir_to_enable_a: assert property (
        (wr_lane0 && hits(avs_address, `MFP_IDX_DIR))
        |-> ##2 ((pin_oe | st_q.seg) == ($past(avs_writedata[7:0], 2) | st_q.seg))
    ) else $error("direction write did not reach pin enables");

    // Segment bits force drive of the LCD value
    seg_override_a: assert property (
        (st_q.seg == 8'hFF)
        |=> (pin_oe == 8'hFF) && (pin_out == $past(lcd_seg))
    ) else $error("segment pins not driven with LCD data");

    // Registers cleared at reset release
    reset_clear_a: assert property (
        $rose(nrst) |-> (st_q.latch == 8'h00) && (st_q.dir == 8'h00) && (st_q.seg == 8'h00)
    ) else $error("port registers not cleared by reset");

    // Input pins read the synchronised pin level
    read_pin_a: assert property (
        (req_new && avs_read && hits(avs_address, `MFP_IDX_LATCH)
         && (st_q.dir == 8'h00) && (st_q.seg == 8'h00))
        |=> !avs_waitrequest && (avs_readdata == {24'h00_0000, $past(st_q.pin_s2)})
    ) else $error("input pins did not read the pin level");

    // Segment input pins read zero
    read_zero_a: assert property (
        (req_new && avs_read && hits(avs_address, `MFP_IDX_LATCH)
         && (st_q.dir == 8'h00) && (st_q.seg == 8'hFF))
        |=> (avs_readdata == 32'h0000_0000)
    ) else $error("segment input pins did not read zero");

    // Output pins read the latch
    read_latch_a: assert property (
        (req_new && avs_read && hits(avs_address, `MFP_IDX_LATCH) && (st_q.dir == 8'hFF))
        |=> (avs_readdata[7:0] == $past(st_q.latch))
    ) else $error("output pins did not read the latch");

    // Every request answered after exactly one wait cycle
    bus_answer_a: assert property (
        req_new |=> !avs_waitrequest ##1 avs_waitrequest
    ) else $error("bus answer not one cycle after request");

    // Latch changes only on an accepted write
    latch_hold_a: assert property (
        !(wr_lane0 && hits(avs_address, `MFP_IDX_LATCH)) |=> $stable(st_q.latch)
    ) else $error("output latch changed without a write");

    // Serial inputs follow port-zero bits when routed here
    sio_route_a: assert property (
        (st_q.route[`MFP_ROUTE_SIO] == 1'b0)
        |=> (func_in.sio_in == $past(st_q.pin_s2[`MFP_BIT_SI]))
            && (func_in.sio_clk_in == $past(st_q.pin_s2[`MFP_BIT_SCK]))
            && !alt_out.sio_clk_oe
    ) else $error("serial routing to port zero wrong");

    // UART on the alternate pins when routed away
    uart_route_a: assert property (
        (st_q.route[`MFP_ROUTE_UART] == 1'b1)
        |=> (alt_out.uart_tx == $past(func_out.uart_tx))
            && (func_in.uart_rx == $past(st_q.alt_s2.uart_rx))
    ) else $error("UART routing to alternate pins wrong");

    // Interrupt inputs follow bits 4 to 2
    int_map_a: assert property (
        1'b1 |=> (func_in.ext_int == $past(st_q.pin_s2[`MFP_BIT_INT_HI:`MFP_BIT_INT_LO]))
    ) else $error("interrupt bit map wrong");

    // Routing register reads back only two bits
    route_bits_a: assert property (
        (req_new && avs_read && hits(avs_address, `MFP_IDX_ROUTE))
        |=> (avs_readdata[31:2] == 30'h0000_0000)
    ) else $error("unimplemented routing bits not zero");

    // Pin enables follow direction and segment bits one edge later
    enable_map_a: assert property (
        1'b1 |=> (pin_oe == $past(st_q.dir | st_q.seg))
    ) else $error("pin enables not direction or segment bits");

    // Pins with no peripheral output drive the latch or the segment value
    plain_drive_a: assert property (
        1'b1 |=> (((pin_out ^ $past((st_q.seg & lcd_seg) | (~st_q.seg & st_q.latch))) & 8'h3D) == 8'h00)
    ) else $error("plain pins not driven from the latch");

    // Every data read mixes latch, pin level and zero bit by bit
    read_mix_a: assert property (
        (req_new && avs_read && hits(avs_address, `MFP_IDX_LATCH))
        |=> (avs_readdata[7:0] == $past((st_q.dir & st_q.latch) | (~st_q.dir & ~st_q.seg & st_q.pin_s2)))
    ) else $error("data read not mixed per bit");

    // Routing write keeps only its two low bits
    route_write_a: assert property (
        (wr_lane0 && hits(avs_address, `MFP_IDX_ROUTE))
        |=> (st_q.route == $past(avs_writedata[1:0]))
    ) else $error("routing write not stored");

    // Serial engine on the alternate pins when routed away
    sio_alt_a: assert property (
        (st_q.route[`MFP_ROUTE_SIO] == 1'b1)
        |=> (func_in.sio_in == $past(st_q.alt_s2.sio_in))
            && (func_in.sio_clk_in == $past(st_q.alt_s2.sio_clk))
            && (alt_out.sio_out == $past(func_out.sio_out))
    ) else $error("serial routing to alternate pins wrong");

    // UART receive on port-zero bit 0, alternate transmit idle high, when routed here
    uart_home_a: assert property (
        (st_q.route[`MFP_ROUTE_UART] == 1'b0)
        |=> (func_in.uart_rx == $past(st_q.pin_s2[`MFP_BIT_RX])) && alt_out.uart_tx
    ) else $error("UART routing to port zero wrong");

    // Scenarios worth seeing
    cov_read_pin_c: cover property (
        req_new && avs_read && hits(avs_address, `MFP_IDX_LATCH) && (st_q.dir != st_q.seg)
    );
    cov_dir_write_c: cover property (
        wr_lane0 && hits(avs_address, `MFP_IDX_DIR) && (avs_writedata[7:0] != 8'h00)
    );
    cov_route_c: cover property (
        st_q.route == 2'h3
    );
    cov_seg_c: cover property (
        (st_q.seg != 8'h00) && (st_q.dir != 8'h00)
    );
    cov_read_zero_c: cover property (
        req_new && avs_read && hits(avs_address, `MFP_IDX_LATCH) && (st_q.seg == 8'hFF) && (st_q.dir == 8'h00)
    );

endmodule // mfp_port

`default_nettype wire

// [tb/mfp_pin_model.sv]
// Board-side model of the port zero pins: resolves every pin from all its drivers
`timescale 1ns/1ps
`default_nettype none

module mfp_pin_model (
    input  wire logic [7:0] pin_out,    // Drive value from the port
    input  wire logic [7:0] pin_oe,     // Drive enables from the port
    input  wire logic [7:0] ext_level,  // Level the board puts on a released pin
    output logic [7:0]      pin_in      // Resolved pin levels back to the port
);

    // A driven pin shows the port's value; a released pin shows the board level,
    // which the bench changes every setup so a stale value never passes
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
    end

endmodule // mfp_pin_model

`default_nettype wire

// [tb/tb_mfp_port.sv]
// Self-checking bench of the multifunction port with random and corner setups
`timescale 1ns/1ps
`default_nettype none
`include "mfp_regs.svh"

module tb_mfp_port;
    import mfp_pkg::*;

    localparam logic [13:0] A_LAT = {`MFP_IDX_LATCH, 2'b00};  // Latch / data word
    localparam logic [13:0] A_DIR = {`MFP_IDX_DIR, 2'b00};    // Direction word
    localparam logic [13:0] A_SEG = {`MFP_IDX_SEG, 2'b00};    // Segment select word
    localparam logic [13:0] A_RTE = {`MFP_IDX_ROUTE, 2'b00};  // Routing word

    logic             sys_clk = 1'b0;          // System clock
    logic             nrst = 1'b0;             // Reset, active low
    logic [13:0]      avs_address = '0;        // Bus address
    logic             avs_read = 1'b0;         // Bus read
    logic             avs_write = 1'b0;        // Bus write
    logic [3:0]       avs_byteenable = '0;     // Bus byte enables
    logic [31:0]      avs_writedata = '0;      // Bus write data
    logic [31:0]      avs_readdata;            // Bus read data
    logic             avs_waitrequest;         // Bus wait
    logic [7:0]       pin_in;                  // Resolved pins
    logic [7:0]       pin_out;                 // Pin drive
    logic [7:0]       pin_oe;                  // Pin enables
    logic [7:0]       pin_ext = '0;            // Board level on released pins
    logic [7:0]       lcd_seg = '0;            // Segment values
    mfp_func_out_type func_out = '1;           // Peripheral outputs
    mfp_func_in_type  func_in;                 // Peripheral inputs
    mfp_alt_in_type   alt_in = '1;             // Alternate pin levels
    mfp_func_out_type alt_out;                 // Alternate pin drive
    int               err_total = 0;           // Mismatches
    int               num_checks = 0;          // Comparisons

    // Clock at 250 MHz
    always #2 sys_clk = ~sys_clk;

    mfp_port i_mfp_port (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .lcd_seg(lcd_seg), .func_out(func_out), .func_in(func_in), .alt_in(alt_in),
        .alt_out(alt_out));

    mfp_pin_model i_mfp_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(pin_ext), .pin_in(pin_in));

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One comparison
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon transfer: held until waitrequest is seen low, data taken at that edge
    task automatic bus(input logic wr, input logic [13:0] adr, input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        int n;
        rd = '0;
        @(posedge sys_clk);
        avs_address <= adr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            err_total++;
            complete_run();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Write the low byte of a register
    task automatic wr8(input logic [13:0] adr, input logic [7:0] d);
        logic [31:0] dummy;
        bus(1'b1, adr, {24'h000000, d}, 4'hF, dummy);
    endtask

    // Expected pin drive: segment wins, else latch gated by any routed peripheral
    function automatic logic [7:0] f_drive(input logic [7:0] l, input logic [7:0] s, input logic [7:0] lc,
                                           input logic [1:0] r, input mfp_func_out_type f);
        logic [7:0] fn;
        fn = 8'hFF;
        if (!r[`MFP_ROUTE_UART]) fn[`MFP_BIT_TX] = f.uart_tx;
        if (!r[`MFP_ROUTE_SIO]) fn[`MFP_BIT_SO] = f.sio_out;
        if (!r[`MFP_ROUTE_SIO]) fn[`MFP_BIT_SCK] = f.sio_clk_out;
        return (s & lc) | (~s & l & fn);
    endfunction

    // Expected peripheral inputs from the pins or the alternate pins
    function automatic mfp_func_in_type f_fin(input logic [7:0] p, input logic [1:0] r, input mfp_alt_in_type a);
        mfp_func_in_type e;
        e.uart_rx = r[`MFP_ROUTE_UART] ? a.uart_rx : p[`MFP_BIT_RX];
        e.sio_in = r[`MFP_ROUTE_SIO] ? a.sio_in : p[`MFP_BIT_SI];
        e.sio_clk_in = r[`MFP_ROUTE_SIO] ? a.sio_clk : p[`MFP_BIT_SCK];
        e.ext_int = p[`MFP_BIT_INT_HI:`MFP_BIT_INT_LO];
        return e;
    endfunction

    // Expected alternate drive: peripheral when routed, idle high and clock released otherwise
    function automatic mfp_func_out_type f_alt(input logic [1:0] r, input mfp_func_out_type f);
        mfp_func_out_type e;
        e.uart_tx = r[`MFP_ROUTE_UART] ? f.uart_tx : 1'b1;
        e.sio_out = r[`MFP_ROUTE_SIO] ? f.sio_out : 1'b1;
        e.sio_clk_out = r[`MFP_ROUTE_SIO] ? f.sio_clk_out : 1'b1;
        e.sio_clk_oe = r[`MFP_ROUTE_SIO] ? f.sio_clk_oe : 1'b0;
        return e;
    endfunction

    // Read the three port registers and compare them with zero
    task automatic chk_reset();
        logic [31:0] d;
        bus(1'b0, A_LAT, '0, 4'hF, d);
        chk("latch_rst", 32'h0, d);
        bus(1'b0, A_DIR, '0, 4'hF, d);
        chk("dir_rst", 32'h0, d);
        bus(1'b0, A_SEG, '0, 4'hF, d);
        chk("seg_rst", 32'h0, d);
        chk("oe_rst", 32'h0, 32'(pin_oe));
    endtask

    // Main sequence
    initial begin
        logic [31:0] r;
        logic [31:0] d;
        logic [7:0]  lat, dir, seg, ext, lcd, oe, eo, p;
        logic [1:0]  rte;
        mfp_func_out_type fo;
        mfp_alt_in_type   ai;
        void'($urandom(32'h64B8C724));
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        chk_reset();
        for (int it = 0; it < 40; it++) begin
            r = $urandom;
            {seg, dir, lat} = r[31:8];
            rte = r[1:0];
            r = $urandom;
            {ai, fo, lcd, ext} = r[22:0];
            // Peripheral outputs on port zero: direction and latch set, segment clear
            if (it == 0) {rte, lat, dir, seg} = {2'b00, 8'hFF, 8'hFF, 8'h00};
            // Segment select over both direction values (0F), latch random
            if (it == 1) {dir, seg} = {8'h0F, 8'hFF};
            // Segment select clear, direction, latch and routing random
            if (it == 2) seg = 8'h00;
            // Segment select on input pins reads back zero
            if (it == 3) {dir, seg} = {8'h00, 8'hFF};
            // routing programmed before the pin settings
            wr8(A_RTE, {6'h00, rte});
            wr8(A_LAT, lat);
            wr8(A_DIR, dir);
            wr8(A_SEG, seg);
            @(posedge sys_clk);
            pin_ext <= ext;
            lcd_seg <= lcd;
            func_out <= fo;
            alt_in <= ai;
            repeat (6) @(posedge sys_clk);
            @(negedge sys_clk);
            oe = dir | seg;
            eo = f_drive(lat, seg, lcd, rte, fo);
            p = (oe & eo) | (~oe & ext);
            chk("pin_oe", 32'(oe), 32'(pin_oe));
            chk("pin_out", 32'(eo & oe), 32'(pin_out & oe));
            chk("func_in", 32'(f_fin(p, rte, ai)), 32'(func_in));
            chk("alt_out", 32'(f_alt(rte, fo)), 32'(alt_out));
            bus(1'b0, A_LAT, '0, 4'hF, d);
            chk("readback", 32'((dir & lat) | (~dir & ~seg & p)), d);
        end
        // Bit set by read-modify-write copies pin levels into input latch bits
        wr8(A_SEG, 8'h00);
        wr8(A_DIR, 8'h0F);
        wr8(A_LAT, 8'h00);
        r = $urandom;
        @(posedge sys_clk);
        pin_ext <= r[7:0];
        repeat (6) @(posedge sys_clk);
        bus(1'b0, A_LAT, '0, 4'hF, d);
        wr8(A_LAT, d[7:0] | 8'h01);
        wr8(A_DIR, 8'hFF);
        bus(1'b0, A_LAT, '0, 4'hF, d);
        chk("rmw_latch", {24'h000000, r[7:4], 4'h1}, d);
        // Unmapped write and disabled byte lane leave the latch alone
        wr8(14'h0004, 8'hA5);
        bus(1'b1, A_LAT, 32'h000000FF, 4'h0, d);
        bus(1'b0, A_LAT, '0, 4'hF, d);
        chk("latch_kept", {24'h000000, r[7:4], 4'h1}, d);
        bus(1'b0, 14'h0004, '0, 4'hF, d);
        chk("unmapped", 32'h0, d);
        // Both routing bits are kept after writing all ones
        wr8(A_RTE, 8'hFF);
        bus(1'b0, A_RTE, '0, 4'hF, d);
        chk("route_bits", 32'h3, 32'(d[1:0]));
        // Reset again in mid-run
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        chk_reset();
        complete_run();
    end

endmodule // tb_mfp_port

`default_nettype wire
